// [rtl/timer_pkg.sv]
package timer_pkg;

  // register byte offsets on the slave bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MODULO = 4'h8;

  // status/control field positions
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_CENTER_ALIGN = 5;
  localparam int CLKS_LSB = 3;
  localparam int PS_LSB = 0;

  // values after reset, the free-running top and the count step
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP_FREE = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // clock source codes; 01 and 10 both pick the bus clock
  localparam logic [1:0] CLKS_NONE = 2'h0;
  localparam logic [1:0] CLKS_BUS_A = 2'h1;
  localparam logic [1:0] CLKS_BUS_B = 2'h2;
  localparam logic [1:0] CLKS_AUX = 2'h3;

  localparam int NUM_CHANNELS = 2;
  localparam int PRESCALE_W = 7;

  typedef struct packed {
    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_align_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
  } sc_fields_t;

  typedef enum logic [1:0] {
    FN_CAPTURE = 2'b00,
    FN_COMPARE = 2'b01,
    FN_EDGE_PWM = 2'b10,
    FN_CENTER_PWM = 2'b11
  } channel_function_t;

  typedef enum logic {
    CLR_IDLE = 1'b0,
    CLR_ARMED = 1'b1
  } clr_state_t;

endpackage

// [rtl/count_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module count_prescaler
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selected, synchronised source
  input wire logic src_tick,
  input wire logic [2:0] prescale_select,
  // divided tick
  output logic count_tick
);

  logic [PRESCALE_W-1:0] div_q;
  logic [PRESCALE_W-1:0] div_d;
  wire [PRESCALE_W:0] mask_wide;
  wire [PRESCALE_W-1:0] mask;

  // divide by 2^n: fire when the low n bits are all ones
  assign mask_wide = (8'h01 << prescale_select) - 8'h01;
  assign mask = mask_wide[PRESCALE_W-1:0];
  // only source ticks advance it, so no source holds it
  assign count_tick = src_tick & ((div_q & mask) == mask);
  assign div_d = src_tick ? div_q + 7'h01 : div_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 7'h00;
    end
    else
    begin
      div_q <= div_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/timer_status_control.sv]
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_status_control
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // clock source pin
  input wire logic auxiliary_internal_pin_clock,
  // channel mode bits
  input wire logic [NUM_CHANNELS-1:0] channel_mode_select_b,
  input wire logic [NUM_CHANNELS-1:0] channel_mode_select_a,
  // to the channels
  output channel_function_t [NUM_CHANNELS-1:0] channel_function,
  output logic count_down,
  output logic count_tick,
  output logic [15:0] counter_value,
  output logic coherency_restart,
  // interrupt request
  output logic overflow_irq
);

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  sc_fields_t sc_q;
  sc_fields_t sc_d;
  clr_state_t clr_q;
  clr_state_t clr_d;
  logic ack_q;
  logic [31:0] readdata_q;
  logic [31:0] rd_mux;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] mod_q;
  logic [15:0] mod_d;
  logic dir_q;
  logic dir_d;
  logic ovf_event;
  logic restart_q;
  logic aux_meta_q;
  logic aux_sync_q;
  logic aux_prev_q;
  logic src_tick;
  logic tick;

  wire req = read | write;
  wire rd_taken = read & ack_q;
  wire wr_taken = write & ack_q;
  wire sc_sel = hit(address, OFS_STATUS_CONTROL);
  wire cnt_sel = hit(address, OFS_COUNTER);
  wire mod_sel = hit(address, OFS_MODULO);
  wire sc_wr = wr_taken & sc_sel;
  wire sc_wr_lane = sc_wr & byteenable[0];
  wire cnt_wr = wr_taken & cnt_sel;
  wire mod_wr = wr_taken & mod_sel;
  // value seen by the read is the flopped one, not a later set
  wire sc_rd_set = rd_taken & sc_sel & readdata_q[BIT_OVERFLOW_FLAG];
  wire flag_clear = sc_wr_lane & ~writedata[BIT_OVERFLOW_FLAG]
    & (clr_q == CLR_ARMED);
  wire [15:0] top = (mod_q == MODULO_RESET) ? COUNT_TOP_FREE : mod_q;

  // one wait state per access: the read data is flopped first
  assign waitrequest = req & ~ack_q;
  assign readdata = readdata_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sc_sel)
    begin
      rd_mux = {24'h00_0000, sc_q};
    end
    else if (cnt_sel)
    begin
      rd_mux = {16'h0000, cnt_q};
    end
    else if (mod_sel)
    begin
      rd_mux = {16'h0000, mod_q};
    end
  end

  // clear sequence; a new overflow or any status/control write disarms it
  always_comb
  begin
    clr_d = clr_q;
    case (clr_q)
      CLR_IDLE:
      begin
        if (sc_rd_set && !ovf_event)
        begin
          clr_d = CLR_ARMED;
        end
      end
      CLR_ARMED:
      begin
        if (ovf_event || sc_wr)
        begin
          clr_d = CLR_IDLE;
        end
      end
      default:
      begin
        clr_d = CLR_IDLE;
      end
    endcase
  end

  always_comb
  begin
    sc_d = sc_q;
    if (sc_wr_lane)
    begin
      sc_d.overflow_irq_enable = writedata[BIT_IRQ_ENABLE];
      sc_d.center_align_select = writedata[BIT_CENTER_ALIGN];
      sc_d.clock_source_select = writedata[CLKS_LSB +: 2];
      sc_d.prescale_select = writedata[PS_LSB +: 3];
    end
    // set wins over clear; a written one changes nothing
    if (ovf_event)
    begin
      sc_d.overflow_flag = 1'b1;
    end
    else if (flag_clear)
    begin
      sc_d.overflow_flag = 1'b0;
    end
  end

  always_comb
  begin
    mod_d = mod_q;
    if (mod_wr && byteenable[0])
    begin
      mod_d[7:0] = writedata[7:0];
    end
    if (mod_wr && byteenable[1])
    begin
      mod_d[15:8] = writedata[15:8];
    end
  end

  // clock source choice
  always_comb
  begin
    case (sc_q.clock_source_select)
      CLKS_NONE: src_tick = 1'b0;
      CLKS_BUS_A: src_tick = 1'b1;
      CLKS_BUS_B: src_tick = 1'b1;
      CLKS_AUX: src_tick = aux_sync_q & ~aux_prev_q;
      default: src_tick = 1'b0;
    endcase
  end

  count_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .src_tick(src_tick),
    .prescale_select(sc_q.prescale_select),
    .count_tick(tick)
  );

  // counter step; tick is zero with no source, so nothing moves
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q & sc_q.center_align_select;
    ovf_event = 1'b0;
    if (cnt_wr)
    begin
      cnt_d = COUNTER_RESET;
      dir_d = 1'b0;
    end
    else if (tick && !sc_q.center_align_select)
    begin
      if (cnt_q == top)
      begin
        cnt_d = COUNTER_RESET;
        ovf_event = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + COUNT_ONE;
      end
    end
    else if (tick && !dir_q)
    begin
      if (cnt_q >= top)
      begin
        cnt_d = cnt_q - COUNT_ONE;
        dir_d = 1'b1;
        ovf_event = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + COUNT_ONE;
      end
    end
    else if (tick)
    begin
      if (cnt_q == COUNTER_RESET)
      begin
        cnt_d = COUNT_ONE;
        dir_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q - COUNT_ONE;
      end
    end
  end

  // channel function per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_chan
      assign channel_function[ch] =
        sc_q.center_align_select ? FN_CENTER_PWM :
        channel_mode_select_b[ch] ? FN_EDGE_PWM :
        channel_mode_select_a[ch] ? FN_COMPARE : FN_CAPTURE;
    end
  endgenerate

  assign overflow_irq = sc_q.overflow_flag
    & sc_q.overflow_irq_enable;
  assign count_down = dir_q;
  assign count_tick = tick;
  assign counter_value = cnt_q;
  assign coherency_restart = restart_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q)
      begin
        readdata_q <= rd_mux;
      end
    end
  end

  // reset clears flag, enable and center select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sc_q <= SC_RESET;
      clr_q <= CLR_IDLE;
      restart_q <= 1'b0;
    end
    else
    begin
      sc_q <= sc_d;
      clr_q <= clr_d;
      restart_q <= sc_wr;
    end
  end

  // two flops into the bus clock, then an edge detect on the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aux_meta_q <= 1'b0;
      aux_sync_q <= 1'b0;
      aux_prev_q <= 1'b0;
    end
    else
    begin
      aux_meta_q <= auxiliary_internal_pin_clock;
      aux_sync_q <= aux_meta_q;
      aux_prev_q <= aux_sync_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= COUNTER_RESET;
      mod_q <= MODULO_RESET;
      dir_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      dir_q <= dir_d;
    end
  end

endmodule
`default_nettype wire

// [tb/timer_status_control_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_status_control_sva
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins and channels
  input wire logic auxiliary_internal_pin_clock,
  input wire logic [NUM_CHANNELS-1:0] channel_mode_select_b,
  input wire logic [NUM_CHANNELS-1:0] channel_mode_select_a,
  input wire channel_function_t [NUM_CHANNELS-1:0] channel_function,
  input wire logic count_down,
  input wire logic count_tick,
  input wire logic [15:0] counter_value,
  input wire logic coherency_restart,
  input wire logic overflow_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_ctl = write && !waitrequest && address == OFS_STATUS_CONTROL;
  wire logic wr_cnt = write && !waitrequest && address == OFS_COUNTER;
  wire logic cen0 = channel_function[0] == FN_CENTER_PWM;
  wire logic cen1 = channel_function[1] == FN_CENTER_PWM;
  wire logic [1:0] own0 = channel_mode_select_b[0] ? FN_EDGE_PWM :
    (channel_mode_select_a[0] ? FN_COMPARE : FN_CAPTURE);

  a_restart_after_write: assert property (
    wr_ctl |=> coherency_restart)
    else $error("no restart after control write");
  a_restart_cause: assert property (
    coherency_restart |-> $past(wr_ctl))
    else $error("restart without control write");
  a_chan_map: assert property (cen0 || channel_function[0] == own0)
    else $error("channel function not from mode bits");
  a_chan_same: assert property (cen0 == cen1)
    else $error("center mode not on all channels");
  a_irq_fall: assert property (
    $fell(overflow_irq) |-> $past(wr_ctl))
    else $error("irq dropped without control write");
  a_irq_rise: assert property (
    $rose(overflow_irq) |-> $past(wr_ctl || count_tick))
    else $error("irq raised without cause");
  a_hold_no_tick: assert property (
    !count_tick && !wr_cnt |=> $stable(counter_value))
    else $error("counter moved without tick");
  a_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered");
endmodule
bind timer_status_control timer_status_control_sva chk_u (.clk, .rst,
  .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .auxiliary_internal_pin_clock, .channel_mode_select_b,
  .channel_mode_select_a, .channel_function, .count_down, .count_tick,
  .counter_value, .coherency_restart, .overflow_irq);
`default_nettype wire

// [tb/timer_status_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_status_control_test
  import timer_pkg::*;
;
  logic clk, rst, read, write, waitrequest, count_down, count_tick;
  logic coherency_restart, overflow_irq;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [1:0] msb, msa;
  logic [3:0] aux_cnt = 4'h0;
  channel_function_t [NUM_CHANNELS-1:0] chf;
  logic [15:0] counter_value;
  int fails, checks_done, n;
  localparam logic [ADDR_W-1:0] CTL = OFS_STATUS_CONTROL;

  timer_status_control dut_u (.clk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest,
    .auxiliary_internal_pin_clock(aux_cnt[2]),
    .channel_mode_select_b(msb), .channel_mode_select_a(msa),
    .channel_function(chf), .count_down, .count_tick, .counter_value,
    .coherency_restart, .overflow_irq);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // pin clock period of 8 bus cycles
  always @(posedge clk) aux_cnt <= aux_cnt + 4'h1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    rd = readdata;
    if (k >= 50) fails++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    access(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // cycles to the next tick, 999 if none
  task automatic tick;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (count_tick !== 1'b1 && n < 999);
  endtask
  // first gap after a change may be short, so skip the first two
  task automatic gap(input int e);
    tick();
    tick();
    tick();
    check(n, e);
  endtask
  task automatic pollflag;
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && k < 300)
    begin
      access(1'b0, CTL, 32'h0);
      k++;
    end
    if (rd[7] !== 1'b1) fails++;
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = 32'h0;
    byteenable = 4'hF;
    msb = 2'b10;
    msa = 2'b01;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(CTL, 32'h0);
    check(chf, {FN_EDGE_PWM, FN_COMPARE});
    msb <= 2'b00;
    msa <= 2'b10;
    @(posedge clk);
    check(chf, {FN_COMPARE, FN_CAPTURE});
    rdc(4'hC, 32'h0);
    for (int p = 0; p < 8; p++)
    begin
      access(1'b1, CTL, {27'h0, p[0] ? 2'h2 : 2'h1, p[2:0]});
      gap(1 << p);
    end
    access(1'b1, CTL, 32'h19);
    gap(16);
    access(1'b1, CTL, 32'h0);
    @(posedge clk);
    check(coherency_restart, 1'b1);
    tick();
    check(n, 999);
    $display("sources and prescaler done");
    access(1'b1, OFS_MODULO, 32'h2);
    access(1'b1, OFS_COUNTER, 32'h0);
    access(1'b1, CTL, 32'h4F);
    pollflag();
    rdc(OFS_COUNTER, 32'h0);
    check(counter_value, 16'h0000);
    check(overflow_irq, 1'b1);
    access(1'b1, CTL, 32'hCF);
    access(1'b1, CTL, 32'h4F);
    rdc(CTL, 32'hCF);
    access(1'b1, CTL, 32'h4F);
    rdc(CTL, 32'h4F);
    check(overflow_irq, 1'b0);
    pollflag();
    repeat (400) @(posedge clk);
    access(1'b1, CTL, 32'h4F);
    rdc(CTL, 32'hCF);
    $display("overflow flag done");
    access(1'b1, CTL, 32'h60);
    rdc(CTL, 32'h60);
    access(1'b1, CTL, 32'h68);
    n = 0;
    while (count_down !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    check(count_down, 1'b1);
    check(chf, {FN_CENTER_PWM, FN_CENTER_PWM});
    rdc(CTL, 32'hE8);
    $display("center mode done");
    summarize();
  end
endmodule
`default_nettype wire
